// ==== rtl/ais_consts.svh ====
`ifndef AIS_CONSTS_SVH
`define AIS_CONSTS_SVH

// register indices, byte address is four times the index
`define AIS_IDX_CTRL_B      8'h03
`define AIS_IDX_RES_LOW     8'h04
`define AIS_IDX_RES_HIGH    8'h05
`define AIS_IDX_CTRL_A      8'h06
`define AIS_IDX_SELECT      8'h07

// reset values
`define AIS_RST_SELECT      8'h00
`define AIS_RST_CTRL        8'h00
`define AIS_RST_RESULT      8'h00

// field positions
`define AIS_REF_MSB         7
`define AIS_REF_LSB         6
`define AIS_CH_MSB          5
`define AIS_CH_LSB          0
`define AIS_CA_ENABLE       7
`define AIS_CA_START        6
`define AIS_CA_DONE         4
`define AIS_CB_BIPOLAR      7
`define AIS_CB_LADJ         3

// channel codes
`define AIS_CH_PIN_LAST     6'h07
`define AIS_CH_DIFF_LAST    6'h1f
`define AIS_CH_GND          6'h20
`define AIS_CH_IREF         6'h21
`define AIS_CH_TEMP         6'h22
`define AIS_CH_CAL_LAST     6'h27

// reference codes
`define AIS_REF_SUPPLY      2'h0
`define AIS_REF_EXT_PIN     2'h1
`define AIS_REF_INT_1V1     2'h2

// conversion lengths in converter clock cycles
`define AIS_CONV_NORMAL     5'h0d
`define AIS_CONV_LONG       5'h19

`endif

// ==== rtl/ais_pkg.sv ====
package ais_pkg;

  typedef enum logic [2:0]
  {
    AIS_IN_PIN     = 3'h0,
    AIS_IN_GND     = 3'h1,
    AIS_IN_IREF    = 3'h2,
    AIS_IN_TEMP    = 3'h3,
    AIS_IN_DIFF    = 3'h4,
    AIS_IN_CAL     = 3'h5,
    AIS_IN_REVDIFF = 3'h6
  } ais_input_kind_t;

  typedef enum logic [1:0]
  {
    AIS_ST_IDLE = 2'b01,
    AIS_ST_CONV = 2'b10
  } ais_state_t;

  typedef struct packed
  {
    logic [5:0]      channel;
    ais_input_kind_t kind;
    logic            gain_20x;
    logic            polarity_swap;
    logic            temp_sensor_en;
  } ais_mux_sel_t;

  typedef struct packed
  {
    logic [1:0] reference_select;
    logic       supply_ref;
    logic       ext_pin_connected;
    logic       internal_ref_en;
  } ais_ref_t;

endpackage

// ==== rtl/ais_converter_control.sv ====
`timescale 1ns/1ps
`include "ais_consts.svh"

module ais_converter_control
  import ais_pkg::*;
#(
  parameter int unsigned ADDR_W   = 12,
  parameter int unsigned CONV_DIV = 2,
  parameter int unsigned SAMPLE_W = 12
)
(
  input  wire logic                       pclk,
  input  wire logic                       presetn,
  input  wire logic                       psel,
  input  wire logic                       penable,
  input  wire logic                       pwrite,
  input  wire logic [ADDR_W-1:0]          paddr,
  input  wire logic [31:0]                pwdata,
  input  wire logic [3:0]                 pstrb,
  output logic      [31:0]                prdata,
  output logic                            pready,
  output logic                            pslverr,
  input  wire logic signed [SAMPLE_W-1:0] sample_value,
  output ais_pkg::ais_mux_sel_t           mux_sel,
  output ais_pkg::ais_ref_t               ref_ctrl,
  output logic                            converting
);
  import ais_pkg::*;

  localparam int DIV_W = (CONV_DIV > 1) ? $clog2(CONV_DIV) : 1;

  initial
  begin
    if (CONV_DIV < 1 || ADDR_W < 5 || SAMPLE_W < 12)
      $error("ais_converter_control: unsupported parameter values");
  end

  ////////////////////////////////////////////////////////////////////////////
  // helpers

  function automatic logic addr_is(input logic [ADDR_W-1:0] a, input logic [7:0] idx);
    addr_is = (a == ADDR_W'({idx, 2'b00}));
  endfunction

  function automatic ais_mux_sel_t decode_channel(input logic [5:0] ch);
    ais_mux_sel_t d;
    d = '0;
    d.channel = ch;
    if (ch <= `AIS_CH_PIN_LAST)
      d.kind = AIS_IN_PIN;
    else if (ch <= `AIS_CH_DIFF_LAST)
      d.kind = AIS_IN_DIFF;
    else if (ch == `AIS_CH_GND)
      d.kind = AIS_IN_GND;
    else if (ch == `AIS_CH_IREF)
      d.kind = AIS_IN_IREF;
    else if (ch == `AIS_CH_TEMP)
      d.kind = AIS_IN_TEMP;
    else if (ch <= `AIS_CH_CAL_LAST)
      d.kind = AIS_IN_CAL;
    else
      d.kind = AIS_IN_REVDIFF;
    if (d.kind == AIS_IN_DIFF || d.kind == AIS_IN_REVDIFF || d.kind == AIS_IN_CAL)
      d.gain_20x = ch[0];
    d.polarity_swap  = (d.kind == AIS_IN_DIFF || d.kind == AIS_IN_REVDIFF) & ch[5];
    d.temp_sensor_en = (ch == `AIS_CH_TEMP);
    decode_channel = d;
  endfunction

  function automatic ais_ref_t decode_ref(input logic [1:0] r);
    ais_ref_t d;
    d = '0;
    d.reference_select  = r;
    d.supply_ref        = (r == `AIS_REF_SUPPLY);
    d.ext_pin_connected = (r == `AIS_REF_EXT_PIN);
    d.internal_ref_en   = (r == `AIS_REF_INT_1V1);
    decode_ref = d;
  endfunction

  function automatic logic is_diff(input ais_input_kind_t k);
    is_diff = (k == AIS_IN_DIFF) || (k == AIS_IN_REVDIFF) || (k == AIS_IN_CAL);
  endfunction

  // sample arrives at 1024-code scale; bipolar halves it to 512 scale
  function automatic logic [9:0] format_result(input logic signed [SAMPLE_W-1:0] s,
                                               input logic                      bip);
    logic signed [SAMPLE_W-1:0] h;
    h = s >>> 1;
    if (bip)
    begin
      if (h < -SAMPLE_W'(512))
        format_result = 10'h200;
      else if (h > SAMPLE_W'(511))
        format_result = 10'h1ff;
      else
        format_result = h[9:0];
    end
    else if (s < 0)
      format_result = 10'h000;
    else if (s > SAMPLE_W'(1023))
      format_result = 10'h3ff;
    else
      format_result = s[9:0];
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // state

  logic [7:0]         select_ff;
  logic               enable_ff;
  logic               done_ff;
  logic               bipolar_ff;
  logic               ladj_ff;
  logic [7:0]         res_low_ff;
  logic [7:0]         res_high_ff;
  ais_state_t         state_ff;
  logic [4:0]         cnt_ff;
  logic [4:0]         len_ff;
  logic [DIV_W-1:0]   div_ff;
  logic               long_ff;
  ais_mux_sel_t       mux_sel_ff;
  ais_ref_t           ref_ctrl_ff;
  logic [31:0]        prdata_ff;
  logic               pready_ff;
  logic               pslverr_ff;

  logic               apb_wr;
  logic               wr_select;
  logic               wr_ctrl_a;
  logic               wr_ctrl_b;
  logic               tick;
  logic               conv_done;
  logic               start;
  logic               long_set;
  logic [9:0]         nxt_result;

  assign apb_wr    = psel & penable & pready_ff & pwrite & pstrb[0];
  assign wr_select = apb_wr & addr_is(paddr, `AIS_IDX_SELECT);
  assign wr_ctrl_a = apb_wr & addr_is(paddr, `AIS_IDX_CTRL_A);
  assign wr_ctrl_b = apb_wr & addr_is(paddr, `AIS_IDX_CTRL_B);
  assign tick      = (div_ff == DIV_W'(CONV_DIV - 1));
  assign conv_done = (state_ff == AIS_ST_CONV) & enable_ff & tick & (cnt_ff == len_ff - 5'h01);
  assign start     = (state_ff == AIS_ST_IDLE) & wr_ctrl_a
                     & pwdata[`AIS_CA_START] & pwdata[`AIS_CA_ENABLE];
  assign long_set  = (wr_ctrl_a & pwdata[`AIS_CA_ENABLE] & ~enable_ff)
                   | (wr_select & (pwdata[`AIS_REF_MSB:`AIS_REF_LSB]
                                   != select_ff[`AIS_REF_MSB:`AIS_REF_LSB]));
  assign nxt_result = format_result(sample_value,
                                    bipolar_ff & is_diff(mux_sel_ff.kind));

  ////////////////////////////////////////////////////////////////////////////
  // apb slave, one access cycle, unmapped addresses answer with pslverr

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata_ff  <= 32'h0;
      pready_ff  <= 1'b0;
      pslverr_ff <= 1'b0;
    end
    else
    begin
      pready_ff  <= psel & ~penable;
      pslverr_ff <= 1'b0;
      prdata_ff  <= 32'h0;
      if (psel && !penable)
      begin
        if (addr_is(paddr, `AIS_IDX_SELECT))
          prdata_ff <= {24'h0, select_ff};
        else if (addr_is(paddr, `AIS_IDX_CTRL_A))
          prdata_ff <= {24'h0, enable_ff, (state_ff == AIS_ST_CONV), 1'b0, done_ff, 4'h0};
        else if (addr_is(paddr, `AIS_IDX_CTRL_B))
          prdata_ff <= {24'h0, bipolar_ff, 3'h0, ladj_ff, 3'h0};
        else if (addr_is(paddr, `AIS_IDX_RES_LOW))
          prdata_ff <= {24'h0, res_low_ff};
        else if (addr_is(paddr, `AIS_IDX_RES_HIGH))
          prdata_ff <= {24'h0, res_high_ff};
        else
          pslverr_ff <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // software registers

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      select_ff  <= `AIS_RST_SELECT;
      enable_ff  <= 1'b0;
      bipolar_ff <= 1'b0;
      ladj_ff    <= 1'b0;
    end
    else
    begin
      if (wr_select)
        select_ff <= pwdata[7:0];
      if (wr_ctrl_a)
        enable_ff <= pwdata[`AIS_CA_ENABLE];
      if (wr_ctrl_b)
      begin
        bipolar_ff <= pwdata[`AIS_CB_BIPOLAR];
        ladj_ff    <= pwdata[`AIS_CB_LADJ];
      end
    end
  end

  // done flag: completion wins over a write-one-to-clear in the same cycle
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      done_ff <= 1'b0;
    else if (conv_done)
      done_ff <= 1'b1;
    else if (wr_ctrl_a && pwdata[`AIS_CA_DONE])
      done_ff <= 1'b0;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      res_low_ff  <= `AIS_RST_RESULT;
      res_high_ff <= `AIS_RST_RESULT;
    end
    else if (conv_done)
    begin
      if (ladj_ff)
      begin
        res_high_ff <= nxt_result[9:2];
        res_low_ff  <= {nxt_result[1:0], 6'h00};
      end
      else
      begin
        res_high_ff <= {6'h00, nxt_result[9:8]};
        res_low_ff  <= nxt_result[7:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // conversion sequencer; prescaler restarts with each conversion so length is exact

  // start consumes the request; a set in the start cycle is already in len_ff
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      long_ff <= 1'b0;
    else if (start)
      long_ff <= 1'b0;
    else if (long_set)
      long_ff <= 1'b1;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_ff <= AIS_ST_IDLE;
      cnt_ff   <= 5'h00;
      len_ff   <= `AIS_CONV_NORMAL;
      div_ff   <= '0;
    end
    else
    begin
      div_ff <= tick ? '0 : div_ff + DIV_W'(1);
      case (state_ff)
        AIS_ST_IDLE:
        begin
          if (start)
          begin
            state_ff <= AIS_ST_CONV;
            cnt_ff   <= 5'h00;
            div_ff   <= '0;
            len_ff   <= (long_ff | long_set) ? `AIS_CONV_LONG : `AIS_CONV_NORMAL;
          end
        end
        AIS_ST_CONV:
        begin
          if (!enable_ff || conv_done)
            state_ff <= AIS_ST_IDLE;
          else if (tick)
            cnt_ff <= cnt_ff + 5'h01;
        end
        default:
          state_ff <= AIS_ST_IDLE;
      endcase
    end
  end

  // working copy only follows the register while no conversion runs
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      mux_sel_ff  <= decode_channel(6'h00);
      ref_ctrl_ff <= decode_ref(2'h0);
    end
    else if (state_ff == AIS_ST_IDLE)
    begin
      mux_sel_ff  <= decode_channel(select_ff[`AIS_CH_MSB:`AIS_CH_LSB]);
      ref_ctrl_ff <= decode_ref(select_ff[`AIS_REF_MSB:`AIS_REF_LSB]);
    end
  end

  assign prdata     = prdata_ff;
  assign pready     = pready_ff;
  assign pslverr    = pslverr_ff;
  assign mux_sel    = mux_sel_ff;
  assign ref_ctrl   = ref_ctrl_ff;
  assign converting = (state_ff == AIS_ST_CONV);

  ////////////////////////////////////////////////////////////////////////////
  // checks

  logic [9:0]  seen_result;
  logic [11:0] run_ff;

  assign seen_result = ladj_ff ? {res_high_ff, res_low_ff[7:6]}
                               : {res_high_ff[1:0], res_low_ff};

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      run_ff <= 12'h000;
    else if (start)
      run_ff <= 12'h001;
    else if (state_ff == AIS_ST_CONV)
      run_ff <= run_ff + 12'h001;
  end

  property p_unipolar_clamp;
    @(posedge pclk) disable iff (!presetn)
    (conv_done && !bipolar_ff && sample_value < 0) |=> (seen_result == 10'h000) && done_ff;
  endproperty
  a_unipolar_clamp: assert property (p_unipolar_clamp) else $error("unipolar clamp");

  property p_bipolar_floor;
    @(posedge pclk) disable iff (!presetn)
    (conv_done && bipolar_ff && is_diff(mux_sel_ff.kind) && sample_value < -SAMPLE_W'(1100))
      |=> seen_result == 10'h200;
  endproperty
  a_bipolar_floor: assert property (p_bipolar_floor) else $error("bipolar floor");

  property p_bipolar_sign;
    @(posedge pclk) disable iff (!presetn)
    (conv_done && bipolar_ff && is_diff(mux_sel_ff.kind))
      |=> seen_result[9] == $past(sample_value < 0);
  endproperty
  a_bipolar_sign: assert property (p_bipolar_sign) else $error("bipolar sign");

  property p_bipolar_by_write;
    @(posedge pclk) disable iff (!presetn)
    $rose(bipolar_ff) |-> $past(wr_ctrl_b && pwdata[`AIS_CB_BIPOLAR]);
  endproperty
  a_bipolar_by_write: assert property (p_bipolar_by_write) else $error("bipolar set");

  property p_gain_swap;
    @(posedge pclk) disable iff (!presetn)
    (mux_sel_ff.kind == AIS_IN_DIFF || mux_sel_ff.kind == AIS_IN_REVDIFF)
      |-> mux_sel_ff.gain_20x == mux_sel_ff.channel[0]
          && mux_sel_ff.polarity_swap == mux_sel_ff.channel[5];
  endproperty
  a_gain_swap: assert property (p_gain_swap) else $error("gain or swap");

  property p_temp;
    @(posedge pclk) disable iff (!presetn)
    mux_sel_ff.temp_sensor_en == (mux_sel_ff.channel == `AIS_CH_TEMP);
  endproperty
  a_temp: assert property (p_temp) else $error("temperature select");

  property p_ref_map;
    @(posedge pclk) disable iff (!presetn)
    ref_ctrl_ff.internal_ref_en == (ref_ctrl_ff.reference_select == `AIS_REF_INT_1V1)
      && ref_ctrl_ff.ext_pin_connected == (ref_ctrl_ff.reference_select == `AIS_REF_EXT_PIN);
  endproperty
  a_ref_map: assert property (p_ref_map) else $error("reference map");

  property p_hold_in_conv;
    @(posedge pclk) disable iff (!presetn)
    (converting && $past(converting)) |-> $stable(mux_sel_ff) && $stable(ref_ctrl_ff);
  endproperty
  a_hold_in_conv: assert property (p_hold_in_conv) else $error("mid conversion change");

  property p_length;
    @(posedge pclk) disable iff (!presetn)
    conv_done |-> run_ff == 12'(len_ff) * 12'(CONV_DIV);
  endproperty
  a_length: assert property (p_length) else $error("conversion length");

  property p_ref_change_long;
    @(posedge pclk) disable iff (!presetn)
    (wr_select && !converting && pwdata[7:6] != select_ff[7:6]) |=> long_ff;
  endproperty
  a_ref_change_long: assert property (p_ref_change_long) else $error("long flag");

  property p_working_copy;
    @(posedge pclk) disable iff (!presetn)
    (!converting ##1 !converting) |-> mux_sel_ff.channel == $past(select_ff[5:0]);
  endproperty
  a_working_copy: assert property (p_working_copy) else $error("working copy");

  c_long_conv: cover property (@(posedge pclk) disable iff (!presetn)
                                conv_done && len_ff == `AIS_CONV_LONG);
  c_short_conv: cover property (@(posedge pclk) disable iff (!presetn)
                                 conv_done && len_ff == `AIS_CONV_NORMAL);
  c_bip_neg: cover property (@(posedge pclk) disable iff (!presetn)
                              conv_done && bipolar_ff && sample_value < 0);
  c_write_mid: cover property (@(posedge pclk) disable iff (!presetn)
                                converting && wr_select);

endmodule

// ==== testbench/ais_analog_model.sv ====
`timescale 1ns/1ps

// far side of the mux: turns the working selection into a 1024-scale sample
module ais_analog_model
  import ais_pkg::*;
#(
  parameter logic [9:0] TEMP_CODE = 10'h12c,
  parameter logic [9:0] IREF_CODE = 10'h3ff
)
(
  input  wire ais_pkg::ais_mux_sel_t mux_sel,
  input  wire ais_pkg::ais_ref_t     ref_ctrl,
  input  wire logic [9:0]            pin_code,
  input  wire logic signed [11:0]    diff_code,
  output logic signed [11:0]         sample_value
);
  int d;

  ////////////////////////////////////////////////////////////////////////////////
  always_comb
  begin
    d = diff_code;
    if (mux_sel.polarity_swap)
      d = -d;
    if (mux_sel.gain_20x)
      d = d * 20;
    // the front end saturates, so big gains must not wrap
    if (d > 2047)
      d = 2047;
    if (d < -2048)
      d = -2048;
    case (mux_sel.kind)
      AIS_IN_PIN:     sample_value = 12'(pin_code + mux_sel.channel[2:0]);
      AIS_IN_GND:     sample_value = 12'h000;
      // reference pin never driven here, internal choices are safe
      AIS_IN_IREF:    sample_value = ref_ctrl.internal_ref_en ? 12'(IREF_CODE) : 12'h155;
      AIS_IN_TEMP:    sample_value = mux_sel.temp_sensor_en ? 12'(TEMP_CODE) : 12'h000;
      AIS_IN_CAL:     sample_value = 12'h000;
      default:        sample_value = 12'(d);
    endcase
  end
endmodule

// ==== testbench/testbench.sv ====
`timescale 1ns/1ps
`include "ais_consts.svh"

module testbench;
  import ais_pkg::*;
  localparam int unsigned CONV_DIV  = 1;
  localparam logic [9:0]  TEMP_CODE = 10'h12c;

  logic                pclk;
  logic                presetn;
  logic                psel;
  logic                penable;
  logic                pwrite;
  logic [11:0]         paddr;
  logic [31:0]         pwdata;
  logic [3:0]          pstrb;
  logic [31:0]         prdata;
  logic                pready;
  logic                pslverr;
  logic signed [11:0]  sample_value;
  ais_mux_sel_t        mux_sel;
  ais_ref_t            ref_ctrl;
  logic                converting;
  logic [9:0]          pin_code;
  logic signed [11:0]  diff_code;
  int                  n_mismatch;
  int                  n_compared;

  ais_converter_control #(.ADDR_W(12), .CONV_DIV(CONV_DIV), .SAMPLE_W(12)) i_ais_converter_control
  (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .sample_value(sample_value), .mux_sel(mux_sel),
    .ref_ctrl(ref_ctrl), .converting(converting)
  );

  ais_analog_model #(.TEMP_CODE(TEMP_CODE)) i_ais_analog_model
  (
    .mux_sel(mux_sel), .ref_ctrl(ref_ctrl), .pin_code(pin_code),
    .diff_code(diff_code), .sample_value(sample_value)
  );

  initial
  begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end

  ////////////////////////////////////////////////////////////////////////////////
  task automatic finish_test();
    $display("checks %0d mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // one idle cycle after each transfer keeps psel from being driven twice in a step
  task automatic apb(input logic wr, input logic [7:0] idx, input logic [31:0] wd,
                     input logic [3:0] st, output logic [31:0] rd, output logic err);
    int i;
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= {2'b00, idx, 2'b00};
    pwdata  <= wd;
    pstrb   <= st;
    @(posedge pclk);
    penable <= 1'b1;
    i = 0;
    do
    begin
      @(posedge pclk);
      i++;
    end
    while (pready !== 1'b1 && i < 20);
    rd = prdata;
    err = pslverr;
    check("pready", pready, 1'b1);
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic wr(input logic [7:0] idx, input logic [31:0] d);
    logic [31:0] r;
    logic        e;
    apb(1'b1, idx, d, 4'hf, r, e);
  endtask

  task automatic rdchk(input string name, input logic [7:0] idx, input logic [31:0] exp);
    logic [31:0] r;
    logic        e;
    apb(1'b0, idx, 32'h0, 4'h0, r, e);
    check(name, r, exp);
  endtask

  task automatic wait_idle();
    int i;
    i = 0;
    while (converting === 1'b1 && i < 200)
    begin
      @(posedge pclk);
      i++;
    end
  endtask

  task automatic measure(input string name, input int exp_len, input logic [9:0] res,
                         input logic la);
    int          len;
    logic [15:0] f;
    f = la ? {res, 6'h00} : {6'h00, res};
    wr(`AIS_IDX_CTRL_A, 32'hc0);
    len = 0;
    while (converting === 1'b1 && len < 200)
    begin
      len++;
      @(posedge pclk);
    end
    check({name, " length"}, len, exp_len * CONV_DIV);
    rdchk({name, " done"}, `AIS_IDX_CTRL_A, 32'h90);
    rdchk({name, " high"}, `AIS_IDX_RES_HIGH, {24'h0, f[15:8]});
    rdchk({name, " low"}, `AIS_IDX_RES_LOW, {24'h0, f[7:0]});
    wr(`AIS_IDX_CTRL_A, 32'h90);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    logic [31:0] r;
    logic        e;
    rdchk("select reset", `AIS_IDX_SELECT, 32'h0);
    rdchk("control b reset", `AIS_IDX_CTRL_B, 32'h0);
    rdchk("result reset", `AIS_IDX_RES_HIGH, 32'h0);
    check("ref reset", ref_ctrl, {2'h0, 1'b1, 1'b0, 1'b0});
    check("mux reset", mux_sel, {6'h00, AIS_IN_PIN, 3'b000});
    apb(1'b0, 8'h00, 32'h0, 4'h0, r, e);
    check("unmapped error", e, 1'b1);
    apb(1'b1, `AIS_IDX_SELECT, 32'h55, 4'h0, r, e);
    rdchk("masked write", `AIS_IDX_SELECT, 32'h0);
    wr(`AIS_IDX_SELECT, 32'h55);
    rdchk("select readback", `AIS_IDX_SELECT, 32'h55);
    $display("test reset done");
  endtask

  task automatic t_select();
    ais_input_kind_t k;
    for (int c = 0; c < 64; c++)
    begin
      wr(`AIS_IDX_SELECT, c);
      @(posedge pclk);
      k = c <= 7 ? AIS_IN_PIN : c <= 31 ? AIS_IN_DIFF : c == 32 ? AIS_IN_GND :
          c == 33 ? AIS_IN_IREF : c == 34 ? AIS_IN_TEMP : c <= 39 ? AIS_IN_CAL :
          AIS_IN_REVDIFF;
      check("channel kind", mux_sel.kind, k);
      check("temp sensor", mux_sel.temp_sensor_en, c == 34);
      if (k == AIS_IN_DIFF || k == AIS_IN_REVDIFF)
      begin
        check("gain", mux_sel.gain_20x, c % 2);
        check("swap", mux_sel.polarity_swap, k == AIS_IN_REVDIFF);
      end
    end
    for (int r = 0; r < 4; r++)
    begin
      wr(`AIS_IDX_SELECT, r << 6);
      @(posedge pclk);
      check("reference", ref_ctrl, {2'(r), r == 0, r == 1, r == 2});
    end
    wr(`AIS_IDX_SELECT, 32'h03);
    $display("test select done");
  endtask

  task automatic t_timing();
    pin_code <= 10'd100;
    wr(`AIS_IDX_CTRL_B, 32'h0);
    measure("first", 25, 10'd103, 1'b0);
    measure("second", 13, 10'd103, 1'b0);
    wr(`AIS_IDX_CTRL_A, 32'h0);
    measure("reenabled", 25, 10'd103, 1'b0);
    wr(`AIS_IDX_CTRL_A, 32'hc0);
    wr(`AIS_IDX_SELECT, 32'h45);
    @(posedge pclk);
    check("busy", converting, 1'b1);
    check("held channel", mux_sel.channel, 6'h03);
    check("held ref", ref_ctrl.reference_select, 2'h0);
    wait_idle();
    @(posedge pclk);
    rdchk("old channel result", `AIS_IDX_RES_LOW, 32'd103);
    check("new channel", mux_sel.channel, 6'h05);
    check("new ref", ref_ctrl.reference_select, 2'h1);
    wr(`AIS_IDX_CTRL_A, 32'h90);
    measure("ref changed", 25, 10'd105, 1'b0);
    wr(`AIS_IDX_CTRL_B, 32'h08);
    measure("left adjust", 13, 10'd105, 1'b1);
    // temperature needs the internal reference and single conversions
    wr(`AIS_IDX_SELECT, 32'ha2);
    measure("temperature", 25, TEMP_CODE, 1'b1);
    $display("test timing done");
  endtask

  task automatic one_fmt(input logic bip, input logic [5:0] ch, input logic signed [11:0] d,
                         input logic [9:0] exp);
    wr(`AIS_IDX_CTRL_B, {24'h0, bip, 7'h00});
    wr(`AIS_IDX_SELECT, {24'h0, 2'h2, ch});
    diff_code <= d;
    measure("format", 13, exp, 1'b0);
  endtask

  task automatic t_formats();
    one_fmt(1'b0, 6'h08, 12'sd100, 10'h064);
    one_fmt(1'b0, 6'h08, -12'sd50, 10'h000);
    one_fmt(1'b0, 6'h08, 12'sd2000, 10'h3ff);
    one_fmt(1'b0, 6'h09, 12'sd30, 10'h258);
    one_fmt(1'b1, 6'h08, 12'sd100, 10'h032);
    one_fmt(1'b1, 6'h08, -12'sd100, 10'h3ce);
    one_fmt(1'b1, 6'h08, -12'sd2000, 10'h200);
    one_fmt(1'b1, 6'h08, 12'sd2000, 10'h1ff);
    one_fmt(1'b1, 6'h28, 12'sd100, 10'h3ce);
    $display("test formats done");
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    n_mismatch = 0;
    n_compared = 0;
    presetn    = 1'b0;
    psel       = 1'b0;
    penable    = 1'b0;
    pwrite     = 1'b0;
    paddr      = 12'h000;
    pwdata     = 32'h0;
    pstrb      = 4'h0;
    pin_code   = 10'h000;
    diff_code  = 12'sd0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_reset();
    t_select();
    t_timing();
    t_formats();
    finish_test();
  end

  // generous bound: the whole sequence needs under nine hundred cycles
  initial
  begin
    repeat (40000) @(posedge pclk);
    n_mismatch++;
    $display("Error watchdog expected finish seen hang");
    finish_test();
  end
endmodule
